// [rtl/bxe_map.vh]
// opcode fields, phase codes and reset values for the bit-op and logic executer
`ifndef BXE_MAP_VH
`define BXE_MAP_VH
`define BXE_OPC_HI 13
`define BXE_OPC_LO 8
`define BXE_OPC_AND 6'h05
`define BXE_BOP_HI 13
`define BXE_BOP_LO 10
`define BXE_BOP_CLR 4'h4
`define BXE_BOP_SET 4'h5
`define BXE_DEST_BIT 7
`define BXE_ADDR_HI 6
`define BXE_ADDR_LO 0
`define BXE_BIT_HI 9
`define BXE_BIT_LO 7
`define BXE_PH_DEC 2'h0
`define BXE_PH_RD 2'h1
`define BXE_PH_PROC 2'h2
`define BXE_PH_WR 2'h3
`define BXE_ACC_RST 8'h00
`define BXE_IR_RST 14'h0000
`define BXE_BYTE_RST 8'h00
`define BXE_ADDR_RST 7'h00
`define BXE_FLAG_RST 1'b0
`define BXE_ZERO_BYTE 8'h00
`endif

// [rtl/bxe_decode.v]
// instruction word decoder for the three supported operations
`timescale 1ns/1ps
`include "bxe_map.vh"
module bxe_decode (
    input wire [13:0] instr,
    output reg is_and,
    output reg is_clr,
    output reg is_set,
    output reg dest_file,
    output reg [6:0] addr,
    output reg [2:0] bit_pos
);
    always @* begin
        is_and = (instr[`BXE_OPC_HI:`BXE_OPC_LO] == `BXE_OPC_AND);
        is_clr = (instr[`BXE_BOP_HI:`BXE_BOP_LO] == `BXE_BOP_CLR);
        is_set = (instr[`BXE_BOP_HI:`BXE_BOP_LO] == `BXE_BOP_SET);
        dest_file = instr[`BXE_DEST_BIT];
        addr = instr[`BXE_ADDR_HI:`BXE_ADDR_LO];
        bit_pos = instr[`BXE_BIT_HI:`BXE_BIT_LO];
    end
endmodule // bxe_decode

// [rtl/bxe_exec.v]
// execute unit: and-with-accumulator, clear bit and set bit over four phases
`timescale 1ns/1ps
`include "bxe_map.vh"
module bxe_exec (
    input wire sys_clk,
    input wire reset,
    input wire [13:0] instr_word,
    input wire instr_valid,
    output wire instr_ready,
    output reg [6:0] rf_addr,
    output reg rf_rd_en,
    input wire [7:0] rf_rd_data,
    output reg rf_wr_en,
    output reg [7:0] rf_wr_data,
    output reg [7:0] accumulator_reg,
    output reg result_null_flag,
    output reg instr_done
);
    // ------------------------------------------------------------
    // phase codes
    // ------------------------------------------------------------
    localparam [1:0] PH_DEC = `BXE_PH_DEC;
    localparam [1:0] PH_RD = `BXE_PH_RD;
    localparam [1:0] PH_PROC = `BXE_PH_PROC;
    localparam [1:0] PH_WR = `BXE_PH_WR;

    // ------------------------------------------------------------
    // state, next values and decoded fields
    // ------------------------------------------------------------
    reg [1:0] phase_q;
    reg [1:0] phase_d;
    reg [13:0] ir_q;
    reg [13:0] ir_d;
    reg busy_q;
    reg busy_d;
    reg [7:0] rd_q;
    reg [7:0] rd_d;
    reg [7:0] res_q;
    reg [7:0] res_d;
    reg [7:0] acc_d;
    reg flag_d;
    reg [6:0] rf_addr_d;
    reg rf_rd_en_d;
    reg rf_wr_en_d;
    reg [7:0] rf_wr_data_d;
    reg done_d;
    wire take;
    wire known_op;
    wire is_and;
    wire is_clr;
    wire is_set;
    wire dest_file;
    wire [6:0] addr;
    wire [2:0] bit_pos;

    function [7:0] bit_mask;
        input [2:0] pos;
        begin
            bit_mask = 8'h01 << pos;
        end
    endfunction

    // ------------------------------------------------------------
    // decoder on the latched word
    // ------------------------------------------------------------
    bxe_decode u_dec (
        .instr(ir_q),
        .is_and(is_and),
        .is_clr(is_clr),
        .is_set(is_set),
        .dest_file(dest_file),
        .addr(addr),
        .bit_pos(bit_pos)
    );

    assign instr_ready = !busy_q;
    assign take = instr_valid && !busy_q;
    assign known_op = is_and | is_clr | is_set;

    // ------------------------------------------------------------
    // phase sequencer and instruction latch
    // ------------------------------------------------------------
    always @* begin
        phase_d = phase_q;
        busy_d = busy_q;
        ir_d = ir_q;
        if (!busy_q) begin
            if (take) begin
                ir_d = instr_word;
                busy_d = 1'b1;
                phase_d = PH_DEC;
            end
        end else begin
            case (phase_q)
                PH_DEC: begin
                    phase_d = PH_RD;
                end
                PH_RD: begin
                    phase_d = PH_PROC;
                end
                PH_PROC: begin
                    phase_d = PH_WR;
                end
                PH_WR: begin
                    busy_d = 1'b0;
                    phase_d = PH_DEC;
                end
                default: begin
                    phase_d = PH_DEC;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // register read: address and strobe in decode, capture in read
    // ------------------------------------------------------------
    always @* begin
        rf_addr_d = rf_addr;
        rf_rd_en_d = 1'b0;
        rd_d = rd_q;
        if (busy_q && (phase_q == PH_DEC)) begin
            rf_addr_d = addr;
            // unknown words neither read nor write
            rf_rd_en_d = known_op;
        end
        if (busy_q && (phase_q == PH_RD)) begin
            rd_d = rf_rd_data;
        end
    end

    // ------------------------------------------------------------
    // process data
    // ------------------------------------------------------------
    always @* begin
        res_d = res_q;
        if (busy_q && (phase_q == PH_PROC)) begin
            if (is_and) begin
                res_d = accumulator_reg & rd_q;
            end else if (is_clr) begin
                res_d = rd_q & ~bit_mask(bit_pos);
            end else if (is_set) begin
                res_d = rd_q | bit_mask(bit_pos);
            end else begin
                res_d = rd_q;
            end
        end
    end

    // ------------------------------------------------------------
    // write destination
    // ------------------------------------------------------------
    always @* begin
        acc_d = accumulator_reg;
        flag_d = result_null_flag;
        rf_wr_en_d = 1'b0;
        rf_wr_data_d = rf_wr_data;
        done_d = 1'b0;
        if (busy_q && (phase_q == PH_WR)) begin
            done_d = 1'b1;
            if (is_and) begin
                flag_d = (res_q == `BXE_ZERO_BYTE);
                if (dest_file) begin
                    rf_wr_en_d = 1'b1;
                    rf_wr_data_d = res_q;
                end else begin
                    acc_d = res_q;
                end
            end else if (is_clr | is_set) begin
                // status flag left untouched
                rf_wr_en_d = 1'b1;
                rf_wr_data_d = res_q;
            end
        end
    end

    // ------------------------------------------------------------
    // flip-flops
    // ------------------------------------------------------------
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            phase_q <= PH_DEC;
            busy_q <= 1'b0;
            ir_q <= `BXE_IR_RST;
        end else begin
            phase_q <= phase_d;
            busy_q <= busy_d;
            ir_q <= ir_d;
        end
    end

    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rd_q <= `BXE_BYTE_RST;
            res_q <= `BXE_BYTE_RST;
        end else begin
            rd_q <= rd_d;
            res_q <= res_d;
        end
    end

    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rf_addr <= `BXE_ADDR_RST;
            rf_rd_en <= 1'b0;
        end else begin
            rf_addr <= rf_addr_d;
            rf_rd_en <= rf_rd_en_d;
        end
    end

    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rf_wr_en <= 1'b0;
            rf_wr_data <= `BXE_BYTE_RST;
            instr_done <= 1'b0;
        end else begin
            rf_wr_en <= rf_wr_en_d;
            rf_wr_data <= rf_wr_data_d;
            instr_done <= done_d;
        end
    end

    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            accumulator_reg <= `BXE_ACC_RST;
            result_null_flag <= `BXE_FLAG_RST;
        end else begin
            accumulator_reg <= acc_d;
            result_null_flag <= flag_d;
        end
    end
endmodule // bxe_exec

// [tb/bxe_rf_model.sv]
// register file model
`timescale 1ns/1ps
module bxe_rf_model (input sys_clk, rf_rd_en, rf_wr_en, input [6:0] rf_addr,
    input [7:0] rf_wr_data, output [7:0] rf_rd_data);
    reg [7:0] mem [0:127];
    assign rf_rd_data = rf_rd_en ? mem[rf_addr] : ~mem[rf_addr];
    always @(posedge sys_clk) if (rf_wr_en) mem[rf_addr] <= rf_wr_data;
endmodule // bxe_rf_model

// [tb/bxe_exec_properties.sv]
// checker for the executer
`timescale 1ns/1ps
module bxe_chk (input sys_clk, reset, instr_valid, instr_ready, rf_rd_en, rf_wr_en,
    input result_null_flag, instr_done, input [13:0] instr_word, input [6:0] rf_addr,
    input [7:0] rf_rd_data, rf_wr_data, accumulator_reg);
    reg [13:0] w_q;
    reg [7:0] d_q;
    wire tk = instr_valid && instr_ready;
    wire fa = instr_done && w_q[13:8] == 6'h05;
    wire [7:0] m = 8'h01 << w_q[9:7];
    always @(posedge sys_clk) if (tk) w_q <= instr_word;
    always @(posedge sys_clk) if (rf_rd_en) d_q <= rf_rd_data;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence s_busy; ##1 !instr_ready [*4]; endsequence
    a_busy_gap: assert property (tk |-> s_busy) else $error("busy");
    a_done_five: assert property (tk |-> ##5 instr_done) else $error("done");
    a_read_addr: assert property (rf_rd_en |-> rf_addr == w_q[6:0]) else $error("addr");
    a_clr_one: assert property (instr_done && w_q[13:10] == 4'h4
        |-> rf_wr_en && rf_wr_data == (d_q & ~m)) else $error("clear");
    a_set_one: assert property (instr_done && w_q[13:10] == 4'h5
        |-> rf_wr_en && rf_wr_data == (d_q | m)) else $error("set");
    a_and_acc: assert property (fa && !w_q[7] |-> !rf_wr_en
        && accumulator_reg == (d_q & $past(accumulator_reg))) else $error("acc");
    a_and_file: assert property (fa && w_q[7] |-> rf_wr_en
        && rf_wr_data == (d_q & accumulator_reg)) else $error("file");
    a_null_flag: assert property (fa |-> result_null_flag
        == ((d_q & $past(accumulator_reg)) == 8'h00)) else $error("flag");
endmodule // bxe_chk
bind bxe_exec bxe_chk chk (.*);

// [tb/tb_bxe_exec.sv]
// bench for the executer
`timescale 1ns/1ps
module tb_bxe_exec;
    reg sys_clk = 1'h0, reset = 1'h1, instr_valid = 1'h0;
    reg [13:0] instr_word = 14'h0000;
    wire instr_ready, rf_rd_en, rf_wr_en, result_null_flag, instr_done;
    wire [6:0] rf_addr;
    wire [7:0] rf_rd_data, rf_wr_data, accumulator_reg;
    integer bad_count = 0, n_tests = 0;
    always #4 sys_clk = ~sys_clk;
    bxe_exec uut (.*);
    bxe_rf_model rf (.*);
    task check(input [7:0] seen, exp, input string msg);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            $display("CHECK FAILED %0t %s", $time, msg);
            bad_count = bad_count + 1;
        end
    endtask
    task report_and_stop;
        $display("%0d of %0d bad", bad_count, n_tests);
        if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // preload accumulator and register while idle, run one word, judge the done cycle
    task go(input [13:0] w, input [7:0] a, v, e, input wr, fl);
        @(negedge sys_clk);
        rf.mem[w[6:0]] = v;
        uut.accumulator_reg = a;
        @(posedge sys_clk);
        instr_word <= w;
        instr_valid <= 1'h1;
        @(posedge sys_clk);
        instr_valid <= 1'h0;
        repeat (5) @(negedge sys_clk);
        check(instr_done, 8'h01, "done");
        check(rf_wr_en, wr, "write strobe");
        check(rf_addr, w[6:0], "address");
        if (wr) check(rf_wr_data, e, "write data");
        check(accumulator_reg, wr ? a : e, "accumulator");
        check(result_null_flag, fl, "zero flag");
        @(negedge sys_clk);
        check(rf.mem[w[6:0]], wr ? e : v, "register");
        check(instr_done, 8'h00, "done pulse");
    endtask
    task t_clr; go(14'h13ff, 8'h5a, 8'hc7, 8'h47, 1'b1, 1'b1); endtask
    task t_set; go(14'h1780, 8'h5a, 8'h0a, 8'h8a, 1'b1, 1'b1); endtask
    task t_file; go(14'h05a3, 8'h17, 8'hc2, 8'h02, 1'b1, 1'b0); endtask
    task t_acc; go(14'h0540, 8'h17, 8'he8, 8'h00, 1'b0, 1'b1); endtask
    task t_rst;
        @(posedge sys_clk);
        reset <= 1'h1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'h0;
        @(negedge sys_clk);
        check(accumulator_reg, 8'h00, "acc after reset");
        check(result_null_flag, 8'h00, "flag after reset");
        check(instr_ready, 8'h01, "ready after reset");
        go(14'h1780, 8'h00, 8'h0a, 8'h8a, 1'b1, 1'b0);
    endtask
    initial begin
        repeat (16) @(posedge sys_clk);
        reset <= 1'h0;
        t_file;
        t_acc;
        t_clr;
        t_set;
        t_rst;
        report_and_stop;
    end
    initial begin
        #3000 bad_count = bad_count + 1;
        report_and_stop;
    end
endmodule // tb_bxe_exec
